// file: src/scs_pkg.sv
`default_nettype none
package scs_pkg;

	// =========================================================
	// Command opcodes and descriptor block layout
	// =========================================================
	localparam logic [7:0] SCS_OP_INQUIRY = 8'h12;
	localparam logic [7:0] SCS_OP_MODE_SELECT = 8'h15;
	localparam logic [7:0] SCS_CDB_LAST = 8'h05;
	localparam int SCS_CDB_BYTES = 6;
	localparam int SCS_CDB_OPCODE = 0;
	localparam int SCS_CDB_FLAGS = 1;
	localparam int SCS_CDB_RSVD_A = 2;
	localparam int SCS_CDB_RSVD_B = 3;
	localparam int SCS_CDB_LENGTH = 4;
	localparam int SCS_CDB_RSVD_C = 5;
	localparam int SCS_PF_BIT = 4;

	// =========================================================
	// Inquiry byte positions and contents
	// =========================================================
	localparam logic [7:0] SCS_INQ_TOTAL = 8'h35;
	localparam logic [5:0] SCS_IDX_VERSION = 6'h02;
	localparam logic [5:0] SCS_IDX_ADDLEN = 6'h04;
	localparam logic [5:0] SCS_IDX_BUF_MSB = 6'h24;
	localparam logic [5:0] SCS_IDX_BUF_LSB = 6'h25;
	localparam logic [5:0] SCS_IDX_GRP0 = 6'h26;
	localparam logic [5:0] SCS_IDX_MAP_00 = 6'h27;
	localparam logic [5:0] SCS_IDX_MAP_08 = 6'h28;
	localparam logic [5:0] SCS_IDX_MAP_10 = 6'h29;
	localparam logic [5:0] SCS_IDX_MAP_18 = 6'h2a;
	localparam logic [5:0] SCS_IDX_GRP1 = 6'h2b;
	localparam logic [5:0] SCS_IDX_MAP_20 = 6'h2c;
	localparam logic [5:0] SCS_IDX_MAP_28 = 6'h2d;
	localparam logic [5:0] SCS_IDX_MAP_30 = 6'h2e;
	localparam logic [5:0] SCS_IDX_MAP_38 = 6'h2f;
	localparam logic [5:0] SCS_IDX_END = 6'h30;
	localparam logic [5:0] SCS_IDX_PROG_ROM = 6'h31;
	localparam logic [5:0] SCS_IDX_CORR_MSB = 6'h32;
	localparam logic [5:0] SCS_IDX_CORR_LSB = 6'h33;
	localparam logic [5:0] SCS_IDX_WORK_RAM = 6'h34;

	localparam logic [7:0] SCS_VAL_VERSION = 8'h02;
	localparam logic [7:0] SCS_VAL_ADDLEN = 8'h30;
	localparam logic [7:0] SCS_VAL_BUF_MSB = 8'h00;
	localparam logic [7:0] SCS_VAL_BUF_LSB = 8'h80;
	localparam logic [7:0] SCS_VAL_GRP0 = 8'h00;
	localparam logic [7:0] SCS_VAL_GRP1 = 8'h01;
	localparam logic [7:0] SCS_VAL_END = 8'hff;
	localparam logic [7:0] SCS_VAL_PROG_ROM = 8'h40;
	localparam logic [7:0] SCS_VAL_CORR_MSB = 8'h01;
	localparam logic [7:0] SCS_VAL_CORR_LSB = 8'h00;
	localparam logic [7:0] SCS_VAL_WORK_RAM = 8'h08;
	localparam logic [7:0] SCS_VAL_MAP_00 = 8'h90;
	localparam logic [7:0] SCS_VAL_MAP_10 = 8'h27;
	localparam logic [7:0] SCS_VAL_MAP_18 = 8'h34;
	localparam logic [7:0] SCS_VAL_MAP_20 = 8'h0c;
	localparam logic [7:0] SCS_VAL_MAP_28 = 8'ha0;
	localparam logic [7:0] SCS_VAL_MAP_30 = 8'h48;
	localparam logic [7:0] SCS_VAL_NONE = 8'h00;

	// =========================================================
	// Parameter page framing
	// =========================================================
	localparam logic [8:0] SCS_PG_HDR_BYTES = 9'h002;

	// =========================================================
	// Carriers and states
	// =========================================================
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} scs_byte_t;

	typedef struct packed {
		logic start;
		logic valid;
		logic [7:0] code;
		logic [7:0] len;
		logic [7:0] idx;
		logic [7:0] data;
	} scs_page_t;

	typedef enum logic [2:0] {
		SCS_ST_IDLE,
		SCS_ST_DISPATCH,
		SCS_ST_INQ_ADDR,
		SCS_ST_INQ_DATA,
		SCS_ST_MS_DATA,
		SCS_ST_DONE
	} scs_state_t;

endpackage
`default_nettype wire

// file: src/scs_inq_rom.sv
`default_nettype none
module scs_inq_rom
	import scs_pkg::*;
(
	input wire logic clk_i,
	input wire logic [5:0] addr_i,
	output logic [7:0] data_o
);

	// Places one flag per opcode, lowest opcode of a span in bit 7.
	function automatic logic [7:0] op_flag(input logic [7:0] op);
		op_flag = 8'h80 >> op[2:0];
	endfunction

	logic [7:0] data_nxt;

	// =========================================================
	// Capability table
	// =========================================================
	always_comb
	begin
		case (addr_i)
			SCS_IDX_VERSION: data_nxt = SCS_VAL_VERSION;
			SCS_IDX_ADDLEN: data_nxt = SCS_VAL_ADDLEN;
			SCS_IDX_BUF_MSB: data_nxt = SCS_VAL_BUF_MSB;
			SCS_IDX_BUF_LSB: data_nxt = SCS_VAL_BUF_LSB;
			SCS_IDX_GRP0: data_nxt = SCS_VAL_GRP0;
			SCS_IDX_MAP_00: data_nxt = op_flag(8'h00) | op_flag(8'h03);
			SCS_IDX_MAP_08: data_nxt = SCS_VAL_NONE;
			SCS_IDX_MAP_10: data_nxt = op_flag(8'h12) | op_flag(8'h15)
				| op_flag(8'h16) | op_flag(8'h17);
			SCS_IDX_MAP_18: data_nxt = op_flag(8'h1a) | op_flag(8'h1b)
				| op_flag(8'h1d);
			SCS_IDX_GRP1: data_nxt = SCS_VAL_GRP1;
			SCS_IDX_MAP_20: data_nxt = op_flag(8'h24) | op_flag(8'h25);
			SCS_IDX_MAP_28: data_nxt = op_flag(8'h28) | op_flag(8'h2a);
			SCS_IDX_MAP_30: data_nxt = op_flag(8'h31) | op_flag(8'h34);
			SCS_IDX_MAP_38: data_nxt = SCS_VAL_NONE;
			SCS_IDX_END: data_nxt = SCS_VAL_END;
			SCS_IDX_PROG_ROM: data_nxt = SCS_VAL_PROG_ROM;
			SCS_IDX_CORR_MSB: data_nxt = SCS_VAL_CORR_MSB;
			SCS_IDX_CORR_LSB: data_nxt = SCS_VAL_CORR_LSB;
			SCS_IDX_WORK_RAM: data_nxt = SCS_VAL_WORK_RAM;
			default: data_nxt = SCS_VAL_NONE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		data_o <= data_nxt;
	end

endmodule // scs_inq_rom
`default_nettype wire

// file: src/scs_cmd_core.sv
// Notes on behaviour
// - Program memory size byte reads 0x40.
// - Working memory size byte reads 0x08.
// - Correction memory size bytes read 0x01, 0x00.
// - Buffer space bytes 36, 37 read 0x00, 0x80.
// - Group 0 field zero, bitmaps follow.
// - Bit 7 flags lowest opcode of span.
// - Span 0x00 bitmap reads 0x90.
// - Spans 0x08 and 0x38 read zero.
// - Span 0x10 bitmap reads 0x27.
// - Span 0x18 bitmap reads 0x34.
// - Group 1 field reads one.
// - Span 0x20 bitmap reads 0x0C.
// - Span 0x28 bitmap reads 0xA0.
// - Span 0x30 bitmap reads 0x48.
// - Bitmap block ends with 0xFF.
// - Opcode 0x15 accepts parameter block.
// - Six byte command, length in byte 4.
// - Zero length list completes without data.
// - Pages start with type and length bytes.
// - Version byte reads 0x02.
// - Additional length fixed at 0x30.
`default_nettype none
module scs_cmd_core
	import scs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire scs_byte_t cmd_i,
	output logic cmd_ready_o,
	output scs_byte_t dout_o,
	input wire logic dout_ready_i,
	input wire scs_byte_t din_i,
	output logic din_ready_o,
	output scs_page_t page_o,
	output logic [7:0] param_len_o,
	output logic page_format_o,
	output logic rsvd_err_o,
	output logic unsup_o,
	output logic busy_o,
	output logic done_o
);

	scs_state_t state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [7:0] limit_r, limit_nxt;
	logic [7:0] plen_r, plen_nxt;
	logic [8:0] pos_r, pos_nxt;
	logic pf_r, pf_nxt;
	logic rsvd_r, rsvd_nxt;
	logic unsup_r, unsup_nxt;
	scs_page_t page_r, page_nxt;
	logic [7:0] cdb_r [SCS_CDB_BYTES];
	logic [7:0] rom_q;
	logic cnt_last;

	// =========================================================
	// Command descriptor capture
	// =========================================================
	genvar g;
	generate
		for (g = 0; g < SCS_CDB_BYTES; g++)
		begin : g_cdb
			logic [7:0] cdb_nxt;
			always_comb
			begin
				cdb_nxt = cdb_r[g];
				if (state_r == SCS_ST_IDLE && cmd_i.valid
					&& cnt_r == 8'(g))
				begin
					cdb_nxt = cmd_i.data;
				end
			end
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					cdb_r[g] <= 8'h00;
				else
					cdb_r[g] <= cdb_nxt;
			end
		end
	endgenerate

	scs_inq_rom u_rom (
		.clk_i(clk_i),
		.addr_i(cnt_r[5:0]),
		.data_o(rom_q)
	);

	assign cnt_last = (8'(cnt_r + 8'h01) == limit_r);

	// =========================================================
	// Command sequencer
	// =========================================================
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		limit_nxt = limit_r;
		plen_nxt = plen_r;
		pos_nxt = pos_r;
		pf_nxt = pf_r;
		rsvd_nxt = rsvd_r;
		unsup_nxt = unsup_r;
		page_nxt = page_r;
		page_nxt.start = 1'b0;
		page_nxt.valid = 1'b0;
		case (state_r)
			SCS_ST_IDLE:
			begin
				if (cmd_i.valid)
				begin
					if (cnt_r == SCS_CDB_LAST)
					begin
						cnt_nxt = 8'h00;
						state_nxt = SCS_ST_DISPATCH;
					end
					else
						cnt_nxt = 8'(cnt_r + 8'h01);
				end
			end
			SCS_ST_DISPATCH:
			begin
				unsup_nxt = 1'b0;
				if (cdb_r[SCS_CDB_OPCODE] == SCS_OP_INQUIRY)
				begin
					// Capability data is never padded past its end.
					if (cdb_r[SCS_CDB_LENGTH] < SCS_INQ_TOTAL)
						limit_nxt = cdb_r[SCS_CDB_LENGTH];
					else
						limit_nxt = SCS_INQ_TOTAL;
					if (cdb_r[SCS_CDB_LENGTH] == 8'h00)
						state_nxt = SCS_ST_DONE;
					else
						state_nxt = SCS_ST_INQ_ADDR;
				end
				else if (cdb_r[SCS_CDB_OPCODE] == SCS_OP_MODE_SELECT)
				begin
					plen_nxt = cdb_r[SCS_CDB_LENGTH];
					pf_nxt = cdb_r[SCS_CDB_FLAGS][SCS_PF_BIT];
					rsvd_nxt = |{cdb_r[SCS_CDB_RSVD_A],
						cdb_r[SCS_CDB_RSVD_B],
						cdb_r[SCS_CDB_RSVD_C]};
					pos_nxt = 9'h000;
					if (cdb_r[SCS_CDB_LENGTH] == 8'h00)
						state_nxt = SCS_ST_DONE;
					else
						state_nxt = SCS_ST_MS_DATA;
				end
				else
				begin
					unsup_nxt = 1'b1;
					state_nxt = SCS_ST_DONE;
				end
			end
			SCS_ST_INQ_ADDR:
				state_nxt = SCS_ST_INQ_DATA;
			SCS_ST_INQ_DATA:
			begin
				if (dout_ready_i)
				begin
					cnt_nxt = 8'(cnt_r + 8'h01);
					if (cnt_last)
						state_nxt = SCS_ST_DONE;
					else
						state_nxt = SCS_ST_INQ_ADDR;
				end
			end
			SCS_ST_MS_DATA:
			begin
				if (din_i.valid)
				begin
					cnt_nxt = 8'(cnt_r + 8'h01);
					if (8'(cnt_r + 8'h01) == plen_r)
						state_nxt = SCS_ST_DONE;
					if (pos_r == 9'h000)
					begin
						page_nxt.code = din_i.data;
						pos_nxt = 9'h001;
					end
					else if (pos_r == 9'h001)
					begin
						page_nxt.len = din_i.data;
						page_nxt.start = 1'b1;
						if (din_i.data == 8'h00)
							pos_nxt = 9'h000;
						else
							pos_nxt = SCS_PG_HDR_BYTES;
					end
					else
					begin
						page_nxt.valid = 1'b1;
						page_nxt.data = din_i.data;
						page_nxt.idx = 8'(pos_r - SCS_PG_HDR_BYTES);
						if (8'(pos_r - 9'h001) == page_r.len)
							pos_nxt = 9'h000;
						else
							pos_nxt = 9'(pos_r + 9'h001);
					end
				end
			end
			SCS_ST_DONE:
			begin
				cnt_nxt = 8'h00;
				state_nxt = SCS_ST_IDLE;
			end
			default:
				state_nxt = SCS_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= SCS_ST_IDLE;
			cnt_r <= 8'h00;
			limit_r <= 8'h00;
			plen_r <= 8'h00;
			pos_r <= 9'h000;
			pf_r <= 1'b0;
			rsvd_r <= 1'b0;
			unsup_r <= 1'b0;
			page_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			limit_r <= limit_nxt;
			plen_r <= plen_nxt;
			pos_r <= pos_nxt;
			pf_r <= pf_nxt;
			rsvd_r <= rsvd_nxt;
			unsup_r <= unsup_nxt;
			page_r <= page_nxt;
		end
	end

	// =========================================================
	// Outputs
	// =========================================================
	assign cmd_ready_o = (state_r == SCS_ST_IDLE);
	assign din_ready_o = (state_r == SCS_ST_MS_DATA);
	assign dout_o = '{valid: (state_r == SCS_ST_INQ_DATA), data: rom_q};
	assign page_o = page_r;
	assign param_len_o = plen_r;
	assign page_format_o = pf_r;
	assign rsvd_err_o = rsvd_r;
	assign unsup_o = unsup_r;
	assign busy_o = (state_r != SCS_ST_IDLE);
	assign done_o = (state_r == SCS_ST_DONE);

	// =========================================================
	// Assertions
	// =========================================================
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_inq_limit;
		dout_o.valid |-> cnt_r < limit_r && limit_r <= SCS_INQ_TOTAL;
	endproperty
	a_inq_limit: assert property (p_inq_limit)
		else $error("inquiry byte beyond allocation length");

	property p_ms_zero;
		state_r == SCS_ST_DISPATCH
			&& cdb_r[SCS_CDB_OPCODE] == SCS_OP_MODE_SELECT
			&& cdb_r[SCS_CDB_LENGTH] == 8'h00
			|=> done_o ##1 !busy_o;
	endproperty
	a_ms_zero: assert property (p_ms_zero)
		else $error("empty parameter list did not complete");

	property p_ms_accept;
		state_r == SCS_ST_DISPATCH
			&& cdb_r[SCS_CDB_OPCODE] == SCS_OP_MODE_SELECT
			&& cdb_r[SCS_CDB_LENGTH] != 8'h00
			|=> din_ready_o && param_len_o == $past(cdb_r[SCS_CDB_LENGTH]);
	endproperty
	a_ms_accept: assert property (p_ms_accept)
		else $error("mode select did not open parameter transfer");

	property p_ms_end;
		din_ready_o && din_i.valid && 8'(cnt_r + 8'h01) == plen_r
			|=> done_o;
	endproperty
	a_ms_end: assert property (p_ms_end)
		else $error("parameter transfer overran its length");

	property p_page_hdr;
		din_ready_o && din_i.valid && pos_r == 9'h001
			|=> page_o.start && page_o.len == $past(din_i.data);
	endproperty
	a_page_hdr: assert property (p_page_hdr)
		else $error("page length byte not reported");

	property p_bitmap_00;
		dout_o.valid && cnt_r[5:0] == SCS_IDX_MAP_00
			|-> dout_o.data == SCS_VAL_MAP_00;
	endproperty
	a_bitmap_00: assert property (p_bitmap_00)
		else $error("span 0x00 bitmap wrong");

	property p_end_mark;
		dout_o.valid && cnt_r[5:0] == SCS_IDX_END
			|-> dout_o.data == SCS_VAL_END;
	endproperty
	a_end_mark: assert property (p_end_mark)
		else $error("end of block marker wrong");

	property p_buf_space;
		dout_o.valid && dout_ready_i && cnt_r[5:0] == SCS_IDX_BUF_MSB
			&& !cnt_last |-> dout_o.data == SCS_VAL_BUF_MSB
			##2 dout_o.valid && dout_o.data == SCS_VAL_BUF_LSB;
	endproperty
	a_buf_space: assert property (p_buf_space)
		else $error("buffer space bytes wrong");

	property p_addlen;
		dout_o.valid && cnt_r[5:0] == SCS_IDX_ADDLEN
			|-> dout_o.data == SCS_VAL_ADDLEN;
	endproperty
	a_addlen: assert property (p_addlen)
		else $error("additional length wrong");

	property p_stall;
		dout_o.valid && !dout_ready_i |=> dout_o.valid && $stable(dout_o.data);
	endproperty
	a_stall: assert property (p_stall)
		else $error("inquiry byte changed while stalled");

	c_inq_full: cover property (dout_o.valid && dout_ready_i
		&& cnt_r[5:0] == SCS_IDX_WORK_RAM);
	c_ms_zero: cover property (state_r == SCS_ST_DISPATCH
		&& cdb_r[SCS_CDB_OPCODE] == SCS_OP_MODE_SELECT
		&& cdb_r[SCS_CDB_LENGTH] == 8'h00);
	c_page_data: cover property (page_o.start ##1 page_o.valid);
	c_unsup: cover property (unsup_o && done_o);

endmodule // scs_cmd_core
`default_nettype wire

// file: verif/scs_host_model.sv
`default_nettype none
module scs_host_model
	import scs_pkg::*;
(
	input wire logic clk_i,
	input wire logic cmd_ready_i,
	input wire logic din_ready_i,
	input wire scs_byte_t dout_i,
	output scs_byte_t cmd_o,
	output scs_byte_t din_o,
	output logic dout_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		cmd_o = '0;
		din_o = '0;
		dout_ready_o = 1'b0;
	end

	// =========================================================
	// Command bytes, sent back to back once the target is idle.
	// =========================================================
	task automatic send_cmd(input logic [7:0] op, input logic [7:0] fl,
		input logic [7:0] len, input logic [7:0] rsv);
		logic [7:0] b [6];
		int n;
		b = '{op, fl, rsv, rsv, len, rsv};
		n = 0;
		@(negedge clk_i);
		while (cmd_ready_i !== 1'b1 && n < 200)
		begin
			n++;
			@(negedge clk_i);
		end
		for (int k = 0; k < 6; k++)
		begin
			cmd_o = '{1'b1, b[k]};
			@(negedge clk_i);
		end
		cmd_o = '{1'b0, ~b[5]};
	endtask

	// =========================================================
	// Inquiry byte receive; ready stays up after the byte.
	// =========================================================
	task automatic take(output logic [7:0] d, input int stall);
		int n;
		n = 0;
		d = 'x;
		if (stall > 0)
		begin
			dout_ready_o = 1'b0;
			repeat (stall) @(negedge clk_i);
		end
		dout_ready_o = 1'b1;
		while (n < 200)
		begin
			@(posedge clk_i);
			n++;
			if (dout_i.valid === 1'b1)
			begin
				d = dout_i.data;
				n = 1000;
			end
		end
		@(negedge clk_i);
	endtask

	// =========================================================
	// Parameter list byte, held until the target takes it.
	// =========================================================
	task automatic send_param(input logic [7:0] b, input int gap);
		int n;
		n = 0;
		if (gap > 0)
		begin
			din_o = '{1'b0, ~din_o.data};
			repeat (gap) @(negedge clk_i);
		end
		din_o = '{1'b1, b};
		while (n < 200)
		begin
			@(posedge clk_i);
			n++;
			if (din_ready_i === 1'b1)
				n = 1000;
		end
		@(negedge clk_i);
	endtask

	task automatic release_all();
		din_o = '{1'b0, ~din_o.data};
		dout_ready_o = 1'b0;
	endtask
endmodule // scs_host_model
`default_nettype wire

// file: verif/scs_cmd_core_tb.sv
`default_nettype none
`define SCS_CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("ERROR t=%0t got %h exp %h", $time, (g), (e)); \
		end \
	end
module scs_cmd_core_tb
	import scs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [7:0] PF_FLAG = 8'h01 << SCS_PF_BIT;
	logic clk_i;
	logic rst_i = 1'b1;
	scs_byte_t cmd_i, dout_o, din_i;
	logic cmd_ready_o, dout_ready_i, din_ready_o;
	scs_page_t page_o;
	logic [7:0] param_len_o;
	logic page_format_o, rsvd_err_o, unsup_o, busy_o, done_o;
	int failures = 0;
	int total_checks = 0;
	int done_cnt = 0;
	int take_cnt = 0;
	int dr_cnt = 0;
	int d0, r0, t0;
	logic [15:0] pg_q [$];
	logic [15:0] pd_q [$];
	logic [7:0] lst_q [$];
	logic [7:0] exp_inq [53];

	scs_cmd_core uut (.clk_i, .rst_i, .cmd_i, .cmd_ready_o, .dout_o,
		.dout_ready_i, .din_i, .din_ready_o, .page_o, .param_len_o,
		.page_format_o, .rsvd_err_o, .unsup_o, .busy_o, .done_o);

	scs_host_model host (.clk_i, .cmd_ready_i(cmd_ready_o),
		.din_ready_i(din_ready_o), .dout_i(dout_o), .cmd_o(cmd_i),
		.din_o(din_i), .dout_ready_o(dout_ready_i));

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		if (done_o === 1'b1)
			done_cnt++;
		if (dout_o.valid === 1'b1 && dout_ready_i === 1'b1)
			take_cnt++;
		if (din_ready_o === 1'b1)
			dr_cnt++;
		if (page_o.start === 1'b1)
			pg_q.push_back({page_o.code, page_o.len});
		if (page_o.valid === 1'b1)
			pd_q.push_back({page_o.idx, page_o.data});
	end

	// =========================================================
	// Command sequencing.
	// =========================================================
	task automatic run_cmd(input logic [7:0] op, input logic [7:0] fl,
		input logic [7:0] len, input logic [7:0] rsv);
		d0 = done_cnt;
		host.send_cmd(op, fl, len, rsv);
		`SCS_CHK(busy_o, 1'b1)
		`SCS_CHK(cmd_ready_o, 1'b0)
	endtask

	task automatic finish_cmd();
		int n;
		n = 0;
		while (done_cnt == d0 && n < 300)
		begin
			@(negedge clk_i);
			n++;
		end
		`SCS_CHK(done_cnt - d0, 1)
	endtask

	task automatic inquiry(input logic [7:0] alloc, input int stall);
		int n;
		logic [7:0] d;
		n = (alloc > 53) ? 53 : alloc;
		t0 = take_cnt;
		run_cmd(SCS_OP_INQUIRY, 8'h00, alloc, 8'h00);
		for (int i = 0; i < n; i++)
		begin
			host.take(d, (i % 2) * stall);
			`SCS_CHK(d, exp_inq[i])
		end
		finish_cmd();
		repeat (4) @(negedge clk_i);
		`SCS_CHK(take_cnt - t0, n)
		host.release_all();
	endtask

	task automatic mode_sel(input logic [7:0] fl, input logic [7:0] rsv);
		pg_q.delete();
		pd_q.delete();
		r0 = dr_cnt;
		run_cmd(SCS_OP_MODE_SELECT, fl, 8'(lst_q.size()), rsv);
		foreach (lst_q[i])
			host.send_param(lst_q[i], (i % 2) * 2);
		finish_cmd();
		host.release_all();
		`SCS_CHK(param_len_o, 8'(lst_q.size()))
		`SCS_CHK(page_format_o, fl[SCS_PF_BIT])
		`SCS_CHK(rsvd_err_o, |rsv)
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (6000) @(posedge clk_i);
		failures++;
		report_and_stop();
	end

	// =========================================================
	// Main sequence.
	// =========================================================
	initial
	begin
		foreach (exp_inq[i])
			exp_inq[i] = 8'h00;
		exp_inq[2] = 8'h02;
		exp_inq[4] = 8'h30;
		exp_inq[36] = 8'h00;
		exp_inq[37] = 8'h80;
		exp_inq[38] = 8'h00;
		exp_inq[39] = 8'h90;
		exp_inq[40] = 8'h00;
		exp_inq[41] = 8'h27;
		exp_inq[42] = 8'h34;
		exp_inq[43] = 8'h01;
		exp_inq[44] = 8'h0c;
		exp_inq[45] = 8'ha0;
		exp_inq[46] = 8'h48;
		exp_inq[47] = 8'h00;
		exp_inq[48] = 8'hff;
		exp_inq[49] = 8'h40;
		exp_inq[50] = 8'h01;
		exp_inq[51] = 8'h00;
		exp_inq[52] = 8'h08;
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		`SCS_CHK(busy_o, 1'b0)
		`SCS_CHK(cmd_ready_o, 1'b1)
		inquiry(8'h35, 2);
		inquiry(8'hff, 0);
		inquiry(8'h28, 1);
		inquiry(8'h00, 0);
		lst_q.delete();
		lst_q = '{8'h00, 8'h03, 8'h1a, 8'h28};
		foreach (lst_q[i])
		begin
			run_cmd(lst_q[i], 8'h00, 8'h00, 8'h00);
			finish_cmd();
			`SCS_CHK(unsup_o, 1'b1)
		end
		inquiry(8'h01, 0);
		`SCS_CHK(unsup_o, 1'b0)
		lst_q = '{8'h00, 8'h02, 8'h11, 8'h22, 8'h02, 8'h01, 8'h33};
		mode_sel(PF_FLAG, 8'h00);
		`SCS_CHK(pg_q.size(), 2)
		`SCS_CHK(pg_q[0], 16'h0002)
		`SCS_CHK(pg_q[1], 16'h0201)
		`SCS_CHK(pd_q.size(), 3)
		`SCS_CHK(pd_q[0], 16'h0011)
		`SCS_CHK(pd_q[1], 16'h0122)
		`SCS_CHK(pd_q[2], 16'h0033)
		lst_q = '{8'h02, 8'h05, 8'haa};
		mode_sel(PF_FLAG, 8'h00);
		`SCS_CHK(pg_q[0], 16'h0205)
		`SCS_CHK(pd_q.size(), 1)
		`SCS_CHK(pd_q[0], 16'h00aa)
		lst_q.delete();
		mode_sel(8'h00, 8'h01);
		`SCS_CHK(dr_cnt - r0, 0)
		`SCS_CHK(pg_q.size(), 0)
		`SCS_CHK(unsup_o, 1'b0)
		report_and_stop();
	end
endmodule // scs_cmd_core_tb
`default_nettype wire
